/* File: inc/vec_unit_cfg.svh */
// Constants for the vector multiply, logic and pack unit
`ifndef VEC_UNIT_CFG_SVH
`define VEC_UNIT_CFG_SVH

`define VEC_MAJOR_HI        31
`define VEC_MAJOR_LO        26
`define VEC_MAJOR_CODE      6'h0A
`define VEC_DEST_HI         25
`define VEC_DEST_LO         21
`define VEC_SRCA_HI         20
`define VEC_SRCA_LO         16
`define VEC_SRCB_HI         15
`define VEC_SRCB_LO         11
`define VEC_RSVD_HI         10
`define VEC_RSVD_LO         8
`define VEC_MINOR_HI        7
`define VEC_MINOR_LO        0

`define VEC_OP_MUL_SUB_SAT  8'h5B
`define VEC_OP_MUL_SAT      8'h5C
`define VEC_OP_NOT_AND      8'h5D
`define VEC_OP_NOT_OR       8'h5E
`define VEC_OP_OR           8'h5F
`define VEC_OP_NIB_PACK     8'h60
`define VEC_OP_BYTE_PACK    8'h61
`define VEC_OP_NIB_PACK_SAT 8'h62

`define VEC_LANES           4
`define VEC_LANE_W          16
`define VEC_BYTES           8
`define VEC_HALF_W          32

`endif

/* File: inc/vec_unit_pkg.sv */
// Types shared by the vector multiply, logic and pack unit
`default_nettype none

package vec_unit_pkg;

  typedef enum logic [2:0] {
    OP_MUL_SUB_SAT,
    OP_MUL_SAT,
    OP_NOT_AND,
    OP_NOT_OR,
    OP_OR,
    OP_NIB_PACK,
    OP_BYTE_PACK,
    OP_NIB_PACK_SAT
  } vec_op_t;

  typedef struct packed {
    logic [4:0] dest_reg;
    logic [4:0] src_a_sel;
    logic [4:0] src_b_sel;
    logic [7:0] minor;
  } vec_fields_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] dest_reg;
    logic [63:0] data;
  } vec_result_t;

endpackage

`default_nettype wire

/* File: hdl/vec_lane_mul.sv */
// One signed 16-bit lane: product, accumulator subtract and saturation
`timescale 1ns/10ps
`default_nettype none

module vec_lane_mul #(
  parameter int LANE_W = 16
) (
  // Operands
  input  wire logic [LANE_W-1:0]   a_i,
  input  wire logic [LANE_W-1:0]   b_i,
  input  wire logic [2*LANE_W-1:0] acc_i,
  // Results
  output logic      [LANE_W-1:0]   mul_sat_o,
  output logic      [LANE_W-1:0]   mul_sub_sat_o
);

  localparam int PW = 2 * LANE_W;

  logic signed [PW-1:0] prod;
  logic signed [PW:0]   diff;
  logic signed [PW-1:0] diff_sat;

  // Two's complement products of LANE_W bits fit in PW bits
  always_comb begin
    prod = $signed({{LANE_W{a_i[LANE_W-1]}}, a_i}) * $signed({{LANE_W{b_i[LANE_W-1]}}, b_i});
    diff = $signed({acc_i[PW-1], acc_i}) - $signed({prod[PW-1], prod});
  end

  // Clamp the product to LANE_W signed bits
  always_comb begin
    if (prod > $signed({{(LANE_W+1){1'b0}}, {(LANE_W-1){1'b1}}})) begin   // RULE_13
      mul_sat_o = {1'b0, {(LANE_W-1){1'b1}}};                           // RULE_14
    end else if (prod < $signed({{(LANE_W+1){1'b1}}, {(LANE_W-1){1'b0}}})) begin
      mul_sat_o = {1'b1, {(LANE_W-1){1'b0}}};                           // RULE_14
    end else begin
      mul_sat_o = prod[LANE_W-1:0];                                     // RULE_05
    end
  end

  // Clamp the difference to PW signed bits, then keep the low lane bits
  always_comb begin
    if (diff[PW] != diff[PW-1]) begin                                   // RULE_13
      diff_sat = diff[PW] ? {1'b1, {(PW-1){1'b0}}} : {1'b0, {(PW-1){1'b1}}};
    end else begin
      diff_sat = diff[PW-1:0];
    end
    mul_sub_sat_o = diff_sat[LANE_W-1:0];                               // RULE_14
  end

endmodule

`default_nettype wire

/* File: hdl/vec_mul_logic_pack_unit.sv */
// Vector multiply, logic and pack execution unit, one cycle latency
//
// Operation
// RULE_01 - Major code 0xA: dest 25:21, src A 20:16, src B 15:11, minor 7:0.
// RULE_02 - Minor 0x5B: accumulator slice minus lane product, clamped 32-bit signed.
// RULE_03 - Lanes 0,1 use low accumulator word halves; lanes 2,3 use high word.
// RULE_04 - Accumulator storage implementation-defined; results follow per-lane listing.
// RULE_05 - Minor 0x5C: signed lane products clamped to 16 bits per lane.
// RULE_06 - Minor 0x5D: bitwise NAND of both 64-bit sources.
// RULE_07 - Minor 0x5E: bitwise NOR of both 64-bit sources.
// RULE_08 - Minor 0x5F: bitwise OR of both 64-bit sources.
// RULE_09 - Minor 0x60: low nibble of each byte, B low word, A high word.
// RULE_10 - Minor 0x61: low byte of each half-word, B low word, A high.
// RULE_11 - Minor 0x62: bytes clamped to signed nibbles, B low, A high.
// RULE_12 - Multiplies use four independent 16-bit lanes, no cross-lane carry.
// RULE_13 - Out-of-range lane results clamp to min or max, never wrap.
// RULE_14 - Clamp to n-bit signed limits; 32-bit result keeps low 16 bits.
// RULE_15 - Only 64-bit operation; no exceptions raised for any opcode.
`timescale 1ns/10ps
`default_nettype none
`include "vec_unit_cfg.svh"

module vec_mul_logic_pack_unit #(
  parameter int DATA_W = 64
) (
  // Clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                clk_en_i,
  // Issue from core
  input  wire logic                issue_valid_i,
  input  wire logic [31:0]         instr_i,
  input  wire logic [DATA_W-1:0]   src_a_reg_i,
  input  wire logic [DATA_W-1:0]   src_b_reg_i,
  // Accumulator slices held by the core
  input  wire logic [DATA_W-1:0]   accumulator_low_word_i,
  input  wire logic [DATA_W-1:0]   accumulator_high_word_i,
  // Decode feedback
  output logic                     claim_o,
  // Write-back to core
  output logic                     result_valid_o,
  output logic [4:0]               result_dest_o,
  output logic [DATA_W-1:0]        result_data_o
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  vec_unit_pkg::vec_fields_t fields;
  vec_unit_pkg::vec_op_t     op;
  logic                      op_known;

  always_comb begin
    fields.dest_reg  = instr_i[`VEC_DEST_HI:`VEC_DEST_LO];              // RULE_01
    fields.src_a_sel = instr_i[`VEC_SRCA_HI:`VEC_SRCA_LO];
    fields.src_b_sel = instr_i[`VEC_SRCB_HI:`VEC_SRCB_LO];
    fields.minor     = instr_i[`VEC_MINOR_HI:`VEC_MINOR_LO];
    op_known         = 1'b1;
    // Reserved bits 10:8 are ignored rather than trapped
    case (fields.minor)
      `VEC_OP_MUL_SUB_SAT:  op = vec_unit_pkg::OP_MUL_SUB_SAT;
      `VEC_OP_MUL_SAT:      op = vec_unit_pkg::OP_MUL_SAT;
      `VEC_OP_NOT_AND:      op = vec_unit_pkg::OP_NOT_AND;
      `VEC_OP_NOT_OR:       op = vec_unit_pkg::OP_NOT_OR;
      `VEC_OP_OR:           op = vec_unit_pkg::OP_OR;
      `VEC_OP_NIB_PACK:     op = vec_unit_pkg::OP_NIB_PACK;
      `VEC_OP_BYTE_PACK:    op = vec_unit_pkg::OP_BYTE_PACK;
      `VEC_OP_NIB_PACK_SAT: op = vec_unit_pkg::OP_NIB_PACK_SAT;
      default: begin
        op       = vec_unit_pkg::OP_OR;
        op_known = 1'b0;
      end
    endcase
  end

  // Other minor codes belong to neighbouring units; no trap from here
  assign claim_o = issue_valid_i && op_known &&                        // RULE_15
                   (instr_i[`VEC_MAJOR_HI:`VEC_MAJOR_LO] == `VEC_MAJOR_CODE);

  // ----------------------------------------------------------------
  // Multiply lanes
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mul_sat;
  logic [DATA_W-1:0] mul_sub_sat;
  logic [2*DATA_W-1:0] acc_all;

  // Accumulator is external; lanes walk low word then high word
  assign acc_all = {accumulator_high_word_i, accumulator_low_word_i};  // RULE_03 RULE_04

  genvar gl;
  generate
    for (gl = 0; gl < `VEC_LANES; gl++) begin : g_lane
      // Each lane is its own multiplier, so no carry crosses lanes
      vec_lane_mul #(
        .LANE_W (`VEC_LANE_W)
      ) u_lane (                                                        // RULE_12
        .a_i           (src_a_reg_i[gl*`VEC_LANE_W +: `VEC_LANE_W]),
        .b_i           (src_b_reg_i[gl*`VEC_LANE_W +: `VEC_LANE_W]),
        .acc_i         (acc_all[gl*2*`VEC_LANE_W +: 2*`VEC_LANE_W]),    // RULE_03
        .mul_sat_o     (mul_sat[gl*`VEC_LANE_W +: `VEC_LANE_W]),        // RULE_05
        .mul_sub_sat_o (mul_sub_sat[gl*`VEC_LANE_W +: `VEC_LANE_W])     // RULE_02
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pack paths
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] nib_pack;
  logic [DATA_W-1:0] nib_pack_sat;
  logic [DATA_W-1:0] byte_pack;
  logic [2*DATA_W-1:0] pack_src;

  // B feeds the low half of the result, A the high half
  assign pack_src = {src_a_reg_i, src_b_reg_i};

  function automatic logic [3:0] clamp_signed_4(input logic [7:0] v);
    if ($signed(v) > $signed(8'h07)) begin                              // RULE_14
      clamp_signed_4 = 4'h7;
    end else if ($signed(v) < $signed(8'hF8)) begin
      clamp_signed_4 = 4'h8;
    end else begin
      clamp_signed_4 = v[3:0];
    end
  endfunction

  genvar gb;
  generate
    for (gb = 0; gb < 2*`VEC_BYTES; gb++) begin : g_nib
      assign nib_pack[gb*4 +: 4]     = pack_src[gb*8 +: 4];            // RULE_09
      assign nib_pack_sat[gb*4 +: 4] = clamp_signed_4(pack_src[gb*8 +: 8]); // RULE_11
    end
    for (gb = 0; gb < 2*`VEC_LANES; gb++) begin : g_byte
      assign byte_pack[gb*8 +: 8] = pack_src[gb*`VEC_LANE_W +: 8];     // RULE_10
    end
  endgenerate

  // ----------------------------------------------------------------
  // Result select
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] result;

  always_comb begin
    case (op)
      vec_unit_pkg::OP_MUL_SUB_SAT:  result = mul_sub_sat;             // RULE_02
      vec_unit_pkg::OP_MUL_SAT:      result = mul_sat;                 // RULE_05
      vec_unit_pkg::OP_NOT_AND:      result = ~(src_a_reg_i & src_b_reg_i); // RULE_06
      vec_unit_pkg::OP_NOT_OR:       result = ~(src_a_reg_i | src_b_reg_i); // RULE_07
      vec_unit_pkg::OP_OR:           result = src_a_reg_i | src_b_reg_i;    // RULE_08
      vec_unit_pkg::OP_NIB_PACK:     result = nib_pack;                // RULE_09
      vec_unit_pkg::OP_BYTE_PACK:    result = byte_pack;               // RULE_10
      vec_unit_pkg::OP_NIB_PACK_SAT: result = nib_pack_sat;            // RULE_11
      default:                       result = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  vec_unit_pkg::vec_result_t out_r;
  vec_unit_pkg::vec_result_t out_nxt;

  // Registering trades a cycle of latency for timing at 250 MHz
  always_comb begin
    out_nxt = out_r;
    if (clk_en_i) begin
      out_nxt.valid = claim_o;
      if (claim_o) begin
        out_nxt.dest_reg = fields.dest_reg;                             // RULE_01
        out_nxt.data     = result;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign result_valid_o = out_r.valid;
  assign result_dest_o  = out_r.dest_reg;
  assign result_data_o  = out_r.data;

endmodule

`default_nettype wire

/* File: tb/vec_unit_assertions.sv */
// Port checker for the vector unit
`timescale 1ns/10ps
`default_nettype none
module vec_unit_chk #(
  parameter int DATA_W = 64
) (
  // Clock, reset and enable
  input wire logic              sys_clk_i,
  input wire logic              sys_rst_i,
  input wire logic              clk_en_i,
  // Watched unit ports
  input wire logic              issue_valid_i,
  input wire logic [31:0]       instr_i,
  input wire logic [DATA_W-1:0] src_a_reg_i,
  input wire logic [DATA_W-1:0] src_b_reg_i,
  input wire logic              claim_o,
  input wire logic              result_valid_o,
  input wire logic [4:0]        result_dest_o,
  input wire logic [DATA_W-1:0] result_data_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic       go = clk_en_i && claim_o;
  wire logic [7:0] mn = instr_i[7:0];
  chk_claim_decode: assert property (claim_o == (issue_valid_i && instr_i[31:26] == 6'h0A
    && mn >= 8'h5B && mn <= 8'h62)) else $error("claim decode wrong");
  chk_valid_follows: assert property (go |=> result_valid_o)
    else $error("no result after claim");
  chk_refused_idle: assert property (clk_en_i && !claim_o |=> !result_valid_o)
    else $error("result without claim");
  chk_hold_idle: assert property (clk_en_i && !claim_o |=> $stable(result_dest_o)
    && $stable(result_data_o)) else $error("result moved without claim");
  chk_dest_field: assert property (go |=> result_dest_o == $past(instr_i[25:21]))
    else $error("dest field wrong");
  chk_nand_data: assert property (go && mn == 8'h5D |=>
    result_data_o == ~$past(src_a_reg_i & src_b_reg_i)) else $error("nand wrong");
  chk_nor_data: assert property (go && mn == 8'h5E |=>
    result_data_o == ~$past(src_a_reg_i | src_b_reg_i)) else $error("nor wrong");
  chk_or_data: assert property (go && mn == 8'h5F |=>
    result_data_o == $past(src_a_reg_i | src_b_reg_i)) else $error("or wrong");
  chk_hold_frozen: assert property (!clk_en_i |=> $stable(result_valid_o)
    && $stable(result_data_o) && $stable(result_dest_o)) else $error("moved while frozen");
endmodule
bind vec_mul_logic_pack_unit vec_unit_chk #(.DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire

/* File: tb/core_reg_model.sv */
// Core register file and accumulator model
`timescale 1ns/10ps
`default_nettype none
module core_reg_model (
  // Issue seen from the core
  input  wire logic        issue_valid_i,
  input  wire logic [31:0] instr_i,
  // Operand and accumulator lines
  output logic      [63:0] src_a_o,
  output logic      [63:0] src_b_o,
  output logic      [63:0] acc_lo_o,
  output logic      [63:0] acc_hi_o
);
  logic [63:0] rf [32];
  logic [63:0] acc_r [2];
  // Core owns the accumulator; the unit only reads it
  assign acc_lo_o = acc_r[0];
  assign acc_hi_o = acc_r[1];
  // Idle operand lines carry junk, never the last value
  always_comb begin
    src_a_o = issue_valid_i ? rf[instr_i[20:16]] : ~rf[instr_i[20:16]];
    src_b_o = issue_valid_i ? rf[instr_i[15:11]] : ~rf[instr_i[15:11]];
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Random self-checking bench for the vector unit
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        clk_en_i = 1'b0;
  logic        issue_valid_i = 1'b0;
  logic [31:0] instr_i = 32'h0;
  logic [31:0] seed = 32'h1727;
  logic [31:0] r, s;
  logic [63:0] a, b, lo, hi, data, exp_data;
  logic [4:0]  dest, exp_dest;
  logic [7:0]  op;
  logic [5:0]  maj;
  logic        claim, valid, exp_valid, exp_claim;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [63:0] pat [4] = '{64'h8000_8000_8000_8000, 64'h7FFF_7FFF_7F80_807F,
                           64'h0001_FFFF_8001_0000, 64'hFF80_7F08_F7FF_0180};
  always #2 sys_clk_i = ~sys_clk_i;
  core_reg_model core (.issue_valid_i(issue_valid_i), .instr_i(instr_i), .src_a_o(a),
    .src_b_o(b), .acc_lo_o(lo), .acc_hi_o(hi));
  vec_mul_logic_pack_unit #(.DATA_W(64)) dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i), .issue_valid_i(issue_valid_i), .instr_i(instr_i), .src_a_reg_i(a),
    .src_b_reg_i(b), .accumulator_low_word_i(lo), .accumulator_high_word_i(hi),
    .claim_o(claim), .result_valid_o(valid), .result_dest_o(dest), .result_data_o(data));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic longint sat(longint v, int n);
    longint m;
    m = (longint'(1) <<< (n - 1)) - 1;
    return v > m ? m : (v < -m - 1 ? -m - 1 : v);
  endfunction
  function automatic logic [63:0] ref_f(logic [7:0] o, logic [63:0] x, y, l, h);
    logic [63:0] q;
    longint p, c;
    q = ~(x & y);
    if (o == 8'h5E) q = ~(x | y);
    if (o == 8'h5F) q = x | y;
    for (int i = 0; i < 8; i++) begin
      p = $signed(x[i%4*16+:16]) * $signed(y[i%4*16+:16]);
      c = $signed(i < 2 ? l[i%2*32+:32] : h[i%2*32+:32]);
      if (o == 8'h5B && i < 4) q[i*16+:16] = 16'(sat(c - p, 32));
      if (o == 8'h5C && i < 4) q[i*16+:16] = 16'(sat(p, 16));
      if (o == 8'h60) q[i*4+:4] = y[i*8+:4];
      if (o == 8'h60) q[32+i*4+:4] = x[i*8+:4];
      if (o == 8'h61 && i < 4) q[i*8+:8] = y[i*16+:8];
      if (o == 8'h61 && i < 4) q[32+i*8+:8] = x[i*16+:8];
      if (o == 8'h62) q[i*4+:4] = 4'(sat($signed(y[i*8+:8]), 4));
      if (o == 8'h62) q[32+i*4+:4] = 4'(sat($signed(x[i*8+:8]), 4));
    end
    return q;
  endfunction
  task automatic check(logic [63:0] seen, logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles > 3000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    for (int i = 0; i < 32; i++) core.rf[i] = 64'h0;
    core.acc_r[0] = 64'h0;
    core.acc_r[1] = 64'h0;
    {exp_valid, exp_claim, exp_dest, exp_data} = '0;
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (2000) begin
      // Let the combinational claim settle after the negedge drive
      #1;
      check({63'h0, claim}, {63'h0, exp_claim});
      @(negedge sys_clk_i);
      check({63'h0, valid}, {63'h0, exp_valid});
      check({59'h0, dest}, {59'h0, exp_dest});
      check(data, exp_data);
      r = rnd();
      s = rnd();
      clk_en_i = r[3:0] != 4'h0;
      issue_valid_i = r[4] | r[5];
      // Mostly legal codes, some neighbours and a wrong major code
      op = r[11:9] == 3'h0 ? 8'h5A + {4'h0, r[15:12]} : 8'h5B + {5'h0, r[8:6]};
      maj = r[18:16] == 3'h0 ? 6'h0B : 6'h0A;
      instr_i = {maj, s[4:0], s[9:5], s[14:10], s[17:15], op};
      core.rf[s[9:5]] = r[20] ? pat[r[22:21]] : {rnd(), rnd()};
      core.rf[s[14:10]] = r[23] ? pat[r[25:24]] : {rnd(), rnd()};
      core.acc_r[r[26]] = r[27] ? 64'h7FFF_FFFF_8000_0000 : {rnd(), rnd()};
      exp_claim = issue_valid_i && maj == 6'h0A && op >= 8'h5B && op <= 8'h62;
      if (clk_en_i)
        exp_valid = exp_claim;
      if (clk_en_i && exp_claim) begin
        exp_dest = s[4:0];
        exp_data = ref_f(op, core.rf[s[9:5]], core.rf[s[14:10]], core.acc_r[0], core.acc_r[1]);
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
